// file: hdl/adcsq_ctrl.sv
// ADC sequencer control: AHB-Lite registers, prescaler, halt and interrupts
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "adcsq_consts.svh"

module adcsq_ctrl import adcsq_pkg::*; #(
	parameter int SETTLE_CYCLES = `ADCSQ_SETTLE_CYCLES,
	parameter int SAMPLE_TICKS = `ADCSQ_SAMPLE_TICKS
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic cpu_halt,
	input wire logic cmp_pin,
	output adcsq_ana_t ana,
	output logic irq
);

	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_chk
		$error("adcsq_ctrl: SETTLE_CYCLES out of range");
	end

	function automatic logic reg_hit(input logic [31:0] a,
		input logic [7:0] idx);
		reg_hit = (a == {22'h0, idx, 2'b00});
	endfunction

	adcsq_ctl_t ctl_reg;
	logic eoc_reg;
	logic [9:0] result_reg;
	logic [1:0] irq_stat_reg;
	logic [1:0] irq_mask_reg;
	logic [31:0] hrdata_reg;
	logic wr_pend_reg;
	logic [31:0] wr_addr_reg;
	logic cmp_s1_reg;
	logic cmp_s2_reg;
	logic cmp_s3_reg;
	logic cmp_level_reg;
	logic cmp_agreed;
	logic [1:0] div_cnt_reg;
	logic halt_q_reg;
	logic [15:0] settle_cnt_reg;

	logic acc;
	logic rd_acc;
	logic rd_high;
	logic csr_wr;
	logic stat_wr;
	logic mask_wr;
	logic [3:0] new_ch;
	logic restart;
	logic settled;
	logic run;
	logic tick;
	logic conv_done;
	logic [9:0] conv_result;
	logic conv_sample;
	logic [9:0] conv_trial;
	logic [31:0] rd_value;

	// Bus side: zero wait states, every answer OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	assign acc = hsel & hready & htrans[1];
	assign rd_acc = acc & ~hwrite;
	assign rd_high = rd_acc & reg_hit(haddr, `ADCSQ_IDX_HIGH);

	assign csr_wr = wr_pend_reg & reg_hit(wr_addr_reg, `ADCSQ_IDX_CSR);
	assign stat_wr = wr_pend_reg & reg_hit(wr_addr_reg, `ADCSQ_IDX_IRQ_STAT);
	assign mask_wr = wr_pend_reg & reg_hit(wr_addr_reg, `ADCSQ_IDX_IRQ_MASK);
	assign new_ch = hwdata[`ADCSQ_CSR_CH_MSB:`ADCSQ_CSR_CH_LSB];

	// A changed channel throws away the conversion under way
	assign restart = csr_wr & (new_ch != ctl_reg.channel); //RULE_11

	// Address phase latched; write data arrive one cycle later
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 32'h00000000;
		end else begin
			wr_pend_reg <= acc & hwrite;
			if (acc & hwrite) begin
				wr_addr_reg <= haddr;
			end
		end
	end

	// Read data sampled at the address phase, held for the data phase
	always_comb begin
		rd_value = 32'h00000000;
		if (reg_hit(haddr, `ADCSQ_IDX_CSR)) begin
			rd_value[`ADCSQ_CSR_EOC] = eoc_reg;
			rd_value[`ADCSQ_CSR_SPEED] = ctl_reg.speed;
			rd_value[`ADCSQ_CSR_ON] = ctl_reg.on;
			rd_value[`ADCSQ_CSR_CH_MSB:`ADCSQ_CSR_CH_LSB] = ctl_reg.channel;
		end else if (reg_hit(haddr, `ADCSQ_IDX_HIGH)) begin
			rd_value[7:0] = result_reg[9:2]; //RULE_01
		end else if (reg_hit(haddr, `ADCSQ_IDX_LOW)) begin
			rd_value[1:0] = result_reg[1:0]; //RULE_01
		end else if (reg_hit(haddr, `ADCSQ_IDX_IRQ_STAT)) begin
			rd_value[1:0] = irq_stat_reg;
		end else if (reg_hit(haddr, `ADCSQ_IDX_IRQ_MASK)) begin
			rd_value[1:0] = irq_mask_reg;
		end else if (reg_hit(haddr, `ADCSQ_IDX_STATUS)) begin
			rd_value[`ADCSQ_ST_SETTLED] = settled;
			rd_value[`ADCSQ_ST_RUNNING] = run;
			rd_value[`ADCSQ_ST_HALTED] = cpu_halt;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hrdata_reg <= 32'h00000000;
		end else if (rd_acc) begin
			hrdata_reg <= rd_value;
		end
	end

	// Control fields; reserved bit 4 is not stored and reads zero
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctl_reg <= adcsq_ctl_t'(6'(`ADCSQ_CSR_RST));
		end else if (csr_wr) begin
			ctl_reg.speed <= hwdata[`ADCSQ_CSR_SPEED];
			ctl_reg.on <= hwdata[`ADCSQ_CSR_ON]; //RULE_06 RULE_07
			ctl_reg.channel <= new_ch; //RULE_05
		end
	end

	// End-of-conversion flag: a completion in the clearing cycle wins
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			eoc_reg <= 1'b0;
		end else if (conv_done) begin
			eoc_reg <= 1'b1; //RULE_08
		end else if (rd_high | csr_wr) begin
			eoc_reg <= 1'b0; //RULE_09 RULE_11
		end
	end

	// Not latched against a pending read: software must read low then high
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			result_reg <= `ADCSQ_RESULT_RST;
		end else if (conv_done) begin
			result_reg <= conv_result; //RULE_08 RULE_10 RULE_14
		end
	end

	// Comparator pin crosses in: three flops, accepted once two agree
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cmp_s1_reg <= 1'b0;
			cmp_s2_reg <= 1'b0;
			cmp_s3_reg <= 1'b0;
			cmp_level_reg <= 1'b0;
		end else begin
			cmp_s1_reg <= cmp_pin;
			cmp_s2_reg <= cmp_s1_reg;
			cmp_s3_reg <= cmp_s2_reg;
			if (cmp_s2_reg == cmp_s3_reg) begin
				cmp_level_reg <= cmp_s3_reg;
			end
		end
	end

	// Agreed level offered in the cycle the flops agree: at the fast clock a
	// decision comes only four cycles after the trial code moves
	assign cmp_agreed = (cmp_s2_reg == cmp_s3_reg) ? cmp_s3_reg :
		cmp_level_reg;

	// Wake from halt: hold off conversions until the analog part settles
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			halt_q_reg <= 1'b0;
			settle_cnt_reg <= 16'h0000;
		end else begin
			halt_q_reg <= cpu_halt;
			if (cpu_halt) begin
				settle_cnt_reg <= 16'h0000;
			end else if (halt_q_reg) begin
				settle_cnt_reg <= 16'(SETTLE_CYCLES); //RULE_16
			end else if (settle_cnt_reg != 16'h0000) begin
				settle_cnt_reg <= settle_cnt_reg - 16'h0001;
			end
		end
	end

	assign settled = (settle_cnt_reg == 16'h0000) & ~halt_q_reg;

	// Of the low-power modes only halt stops the converter; processor wait has no input here
	assign run = ctl_reg.on & ~cpu_halt & settled; //RULE_07 RULE_15 RULE_16

	// Prescaler restarts with the channel so each conversion has equal ticks
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt_reg <= 2'h0;
		end else if (!run || restart) begin
			div_cnt_reg <= 2'h0;
		end else begin
			div_cnt_reg <= div_cnt_reg + 2'h1;
		end
	end

	assign tick = run & (ctl_reg.speed ? div_cnt_reg[0] :
		(div_cnt_reg == 2'h3)); //RULE_12

	adcsq_sar #(
		.RES_BITS(10),
		.SAMPLE_TICKS(SAMPLE_TICKS)
	) u_sar (
		.core_clk(core_clk),
		.nrst(nrst),
		.tick(tick),
		.run(run),
		.restart(restart),
		.cmp_level(cmp_agreed),
		.sample(conv_sample),
		.trial(conv_trial),
		.done(conv_done),
		.result(conv_result)
	);

	// Analog side: power follows the on bit and is cut in halt
	always_comb begin
		ana.power = ctl_reg.on & ~cpu_halt; //RULE_07 RULE_16
		ana.sample = conv_sample & run;
		ana.channel = ctl_reg.channel; //RULE_05
		ana.trial = conv_trial;
	end

	// Sticky events, write one to clear; a new event beats the clear
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat_reg <= `ADCSQ_IRQ_RST;
		end else begin
			if (conv_done) begin
				irq_stat_reg[`ADCSQ_IRQ_DONE] <= 1'b1;
			end else if (stat_wr && hwdata[`ADCSQ_IRQ_DONE]) begin
				irq_stat_reg[`ADCSQ_IRQ_DONE] <= 1'b0;
			end
			// Overrun: a result replaced before the high byte was read
			if (conv_done && eoc_reg && !rd_high) begin
				irq_stat_reg[`ADCSQ_IRQ_OVERRUN] <= 1'b1;
			end else if (stat_wr && hwdata[`ADCSQ_IRQ_OVERRUN]) begin
				irq_stat_reg[`ADCSQ_IRQ_OVERRUN] <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_mask_reg <= `ADCSQ_IRQ_RST;
		end else if (mask_wr) begin
			irq_mask_reg <= hwdata[1:0];
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule

// file: hdl/adcsq_consts.svh
// Register map, field positions, reset values and timing for the ADC sequencer
// Function
// RULE_01: Result bits 9:2 high, 1:0 low register
// RULE_02: Input above high reference reads full scale
// RULE_03: Input below low reference reads zero
// RULE_04: Codes never move against the input
// RULE_05: Four-bit binary field selects one of sixteen inputs
// RULE_06: Setting converter_on starts continuous conversion
// RULE_07: Clearing converter_on stops converter immediately
// RULE_08: Completion sets flag and loads result
// RULE_09: High read or control write clears flag
// RULE_10: Every conversion overwrites both result registers
// RULE_11: Channel change abandons conversion, clears flag, restarts
// RULE_12: Clock select: 0 divides by four, 1 by two
// RULE_13: Software writes zero to reserved bit 4
// RULE_14: Software polls flag, reads low, then high
// RULE_15: Processor wait mode leaves converter running
// RULE_16: Halt disables converter; settle time after wake
// RULE_17: Fixed sampling ticks plus ten bit decisions
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH

`define ADCSQ_IDX_CSR 8'h70
`define ADCSQ_IDX_HIGH 8'h71
`define ADCSQ_IDX_LOW 8'h72
`define ADCSQ_IDX_IRQ_STAT 8'h73
`define ADCSQ_IDX_IRQ_MASK 8'h74
`define ADCSQ_IDX_STATUS 8'h75

`define ADCSQ_CSR_EOC 7
`define ADCSQ_CSR_SPEED 6
`define ADCSQ_CSR_ON 5
`define ADCSQ_CSR_CH_MSB 3
`define ADCSQ_CSR_CH_LSB 0

`define ADCSQ_IRQ_DONE 0
`define ADCSQ_IRQ_OVERRUN 1

`define ADCSQ_ST_SETTLED 0
`define ADCSQ_ST_RUNNING 1
`define ADCSQ_ST_HALTED 2

`define ADCSQ_CSR_RST 8'h00
`define ADCSQ_RESULT_RST 10'h000
`define ADCSQ_IRQ_RST 2'h0

`define ADCSQ_CLK_MHZ 100
`define ADCSQ_SETTLE_NS 30000
`define ADCSQ_SETTLE_CYCLES ((`ADCSQ_SETTLE_NS * `ADCSQ_CLK_MHZ + 999) / 1000)
`define ADCSQ_SAMPLE_TICKS 4

`endif

// file: hdl/adcsq_pkg.sv
// Types shared by the ADC sequencer modules
package adcsq_pkg;

	typedef enum logic [3:0] {
		SAR_IDLE = 4'b0001,
		SAR_SAMPLE = 4'b0010,
		SAR_SETTLE = 4'b0100,
		SAR_DECIDE = 4'b1000
	} adcsq_sar_state_t;

	typedef struct packed {
		logic power;
		logic sample;
		logic [3:0] channel;
		logic [9:0] trial;
	} adcsq_ana_t;

	typedef struct packed {
		logic speed;
		logic on;
		logic [3:0] channel;
	} adcsq_ctl_t;

endpackage

// file: hdl/adcsq_sar.sv
// Successive-approximation sequencer: sampling phase and bit decisions
`timescale 1ns/1ps
`include "adcsq_consts.svh"

module adcsq_sar import adcsq_pkg::*; #(
	parameter int RES_BITS = 10,
	parameter int SAMPLE_TICKS = `ADCSQ_SAMPLE_TICKS
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic tick,
	input wire logic run,
	input wire logic restart,
	input wire logic cmp_level,
	output logic sample,
	output logic [9:0] trial,
	output logic done,
	output logic [9:0] result
);

	if (RES_BITS != 10 || SAMPLE_TICKS < 1 || SAMPLE_TICKS > 15) begin : g_chk
		$error("adcsq_sar: unsupported parameter values");
	end

	adcsq_sar_state_t state_reg;
	logic [3:0] samp_cnt_reg;
	logic [3:0] bit_reg;
	logic [9:0] code_reg;
	logic [9:0] kept;

	// Comparator high means the input is at or above the trial level, so
	// a rising input can only keep more bits set
	always_comb begin
		kept = cmp_level ? code_reg : (code_reg & ~(10'h001 << bit_reg)); //RULE_04
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= SAR_IDLE;
			samp_cnt_reg <= 4'h0;
			bit_reg <= 4'h0;
			code_reg <= 10'h000;
			done <= 1'b0;
			result <= `ADCSQ_RESULT_RST;
		end else begin
			done <= 1'b0;
			if (!run) begin
				state_reg <= SAR_IDLE; //RULE_07
			end else if (restart) begin
				state_reg <= SAR_SAMPLE; //RULE_11
				samp_cnt_reg <= 4'h0;
			end else if (tick) begin
				unique case (state_reg)
				SAR_IDLE: begin
					state_reg <= SAR_SAMPLE; //RULE_06
					samp_cnt_reg <= 4'h0;
				end
				SAR_SAMPLE: begin
					samp_cnt_reg <= samp_cnt_reg + 4'h1;
					if (samp_cnt_reg == 4'(SAMPLE_TICKS - 1)) begin //RULE_17
						state_reg <= SAR_SETTLE;
						bit_reg <= 4'h9;
						code_reg <= 10'h200;
					end
				end
				// Two ticks per bit give the comparator synchroniser time
				SAR_SETTLE: begin
					state_reg <= SAR_DECIDE;
				end
				SAR_DECIDE: begin
					if (bit_reg == 4'h0) begin
						result <= kept; //RULE_02 RULE_03
						done <= 1'b1;
						state_reg <= SAR_SAMPLE; //RULE_06
						samp_cnt_reg <= 4'h0;
					end else begin
						code_reg <= kept | (10'h001 << (bit_reg - 4'h1));
						bit_reg <= bit_reg - 4'h1;
						state_reg <= SAR_SETTLE;
					end
				end
				endcase
			end
		end
	end

	assign sample = (state_reg == SAR_SAMPLE);
	assign trial = code_reg;

endmodule

// file: sim/adcsq_ctrl_sva.sv
// Concurrent checks on the ADC sequencer bus and analog port
`timescale 1ns/1ps
module adcsq_ctrl_chk import adcsq_pkg::*; #(
	parameter int SAMPLE_TICKS = 4
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic cpu_halt,
	input wire adcsq_ana_t ana
);
	localparam int SMAX = SAMPLE_TICKS * 4 + 8;
	logic take;
	assign take = hsel && hready && htrans[1];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	chk_halt_power: assert property (cpu_halt [*2] |-> !ana.power)
		else $error("converter powered during halt");
	chk_chan_write: assert property (take && hwrite
		&& haddr == 32'h1C0 ##1 1 |=> ana.channel == $past(hwdata[3:0]))
		else $error("channel not applied");
	chk_off_write: assert property (take && hwrite && haddr == 32'h1C0
		##1 !hwdata[5] |=> !ana.power) else $error("converter not stopped");
	chk_idle_sample: assert property (!ana.power [*2] |-> !ana.sample)
		else $error("sampling while unpowered");
	chk_low_field: assert property (take && !hwrite && haddr == 32'h1C8
		|=> hrdata[31:2] == 30'h0) else $error("low result upper bits set");
	chk_high_field: assert property (take && !hwrite && haddr == 32'h1C4
		|=> hrdata[31:8] == 24'h0) else $error("high result too wide");
	chk_sample_bound: assert property (ana.sample |-> ##[1:SMAX] !ana.sample)
		else $error("sampling phase too long");
endmodule

bind adcsq_ctrl adcsq_ctrl_chk #(.SAMPLE_TICKS(SAMPLE_TICKS)) u_adcsq_ctrl_chk (
	.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.cpu_halt(cpu_halt), .ana(ana));

// file: sim/adcsq_analog.sv
// Behavioural analog front end: input levels, multiplexer and comparator
`timescale 1ns/1ps
module adcsq_analog import adcsq_pkg::*; (
	input wire logic core_clk,
	input wire adcsq_ana_t ana,
	output logic cmp_pin
);
	int vin [16];
	logic wander = 1'b0;
	initial foreach (vin[i]) vin[i] = 0;
	// Unpowered comparator output is not driven, so it wanders
	always @(posedge core_clk) wander <= ~wander;
	assign cmp_pin = ana.power ?
		(vin[ana.channel] >= int'(ana.trial)) : wander;
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the ADC sequencer control block
`timescale 1ns/1ps
module tb_top;
	localparam logic [31:0] CSR = 32'h1C0;
	localparam logic [31:0] HIGH = 32'h1C4;
	localparam logic [31:0] LOW = 32'h1C8;
	localparam logic [31:0] STAT = 32'h1CC;
	localparam logic [31:0] MASK = 32'h1D0;
	logic core_clk = 0, nrst = 0, hsel = 0, hwrite = 0, cpu_halt = 0;
	logic hready, hresp, irq, cmp_pin;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] rst_addr [6] = '{CSR, HIGH, LOW, STAT, MASK, 32'h1E0};
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	adcsq_pkg::adcsq_ana_t ana;
	int err_count = 0, compares = 0, cyc = 0, n;

	adcsq_ctrl #(.SETTLE_CYCLES(5)) u_adcsq_ctrl (.core_clk(core_clk),
		.nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
		.cpu_halt(cpu_halt), .cmp_pin(cmp_pin), .ana(ana), .irq(irq));
	adcsq_analog u_adcsq_analog (.core_clk(core_clk), .ana(ana),
		.cmp_pin(cmp_pin));

	initial forever #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end

	function automatic int code(int v);
		return v < 0 ? 0 : (v > 1023 ? 1023 : v);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	// Counts cycles so callers can tell the two prescaler settings apart
	task automatic wait_eoc();
		int t0;
		t0 = cyc;
		do bus(1'b0, CSR, 32'h0); while (r[7] !== 1'b1 && cyc - t0 < 2000);
		n = cyc - t0;
		chk(32'(r[7]), 32'h1);
	endtask
	task automatic conv(input int ch, input int v, input logic sp);
		u_adcsq_analog.vin[ch] = v;
		bus(1'b1, CSR, {25'h0, sp, 2'h2, 4'(ch)});
		wait_eoc();
		chk(32'(n < 75), 32'(sp));
		bus(1'b0, LOW, 32'h0);
		chk(r, 32'(code(v) % 4));
		bus(1'b0, HIGH, 32'h0);
		chk(r, 32'(code(v) / 4));
		bus(1'b0, CSR, 32'h0);
		chk(32'(r[7]), 32'h0);
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		void'($urandom(78636));
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		foreach (rst_addr[i]) begin
			bus(1'b0, rst_addr[i], 32'h0);
			chk(r, 32'h0);
		end
		$display("reset values done");
		for (int i = 0; i < 16; i++)
			conv(i, i == 0 ? -5 : (i == 15 ? 1500 :
				i * 64 + $urandom_range(63)), i[0]);
		$display("conversions done");
		u_adcsq_analog.vin[9] = 900;
		bus(1'b1, CSR, 32'h23);
		repeat (30) @(posedge core_clk);
		bus(1'b1, CSR, 32'h29);
		bus(1'b0, CSR, 32'h0);
		chk(32'(r[7]), 32'h0);
		wait_eoc();
		chk(32'(n >= 85), 32'h1);
		bus(1'b0, HIGH, 32'h0);
		chk(r, 32'd225);
		u_adcsq_analog.vin[9] = 401;
		wait_eoc();
		bus(1'b1, CSR, 32'h29);
		bus(1'b0, CSR, 32'h0);
		chk(32'(r[7]), 32'h0);
		wait_eoc();
		bus(1'b0, LOW, 32'h0);
		chk(r, 32'h1);
		bus(1'b0, HIGH, 32'h0);
		chk(r, 32'd100);
		$display("channel change done");
		cpu_halt <= 1'b1;
		bus(1'b1, CSR, 32'h29);
		repeat (300) @(posedge core_clk);
		bus(1'b0, CSR, 32'h0);
		chk(32'(r[7]), 32'h0);
		bus(1'b0, 32'h1D4, 32'h0);
		chk(r, 32'h4);
		cpu_halt <= 1'b0;
		wait_eoc();
		bus(1'b1, CSR, 32'h09);
		repeat (300) @(posedge core_clk);
		bus(1'b0, CSR, 32'h0);
		chk(r, 32'h09);
		$display("halt and off done");
		bus(1'b1, STAT, 32'h3);
		bus(1'b1, MASK, 32'h1);
		bus(1'b1, CSR, 32'h69);
		wait_eoc();
		#1 chk(32'(irq), 32'h1);
		bus(1'b0, STAT, 32'h0);
		chk(r, 32'h1);
		bus(1'b1, MASK, 32'h0);
		#1 chk(32'(irq), 32'h0);
		bus(1'b1, CSR, 32'h0);
		bus(1'b1, STAT, 32'h3);
		bus(1'b1, MASK, 32'h1);
		#1 chk(32'(irq), 32'h0);
		$display("interrupt done");
		stop_test();
	end
endmodule
